// file: hdl/tput_pkg.sv
// package of constants shared by the throughput monitor and its counter slice
// assumes a single system clock; no register bus reaches these values
package tput_pkg;
  localparam int CLK_HZ = 10000000;
  localparam int INTERVAL_S = 1;
  localparam int INTERVAL_CYC = CLK_HZ * INTERVAL_S;
  localparam int CNT_W = 32;
  localparam int BEAT_BYTES = 8;
  localparam int LINK_DATA_W = 64;
  localparam int LINK_CLK_KHZ = 156250;
  localparam int FRAME_CHAR_BYTES = 2;
  localparam int MIN_IFG_BEATS = 3;
  localparam int MIN_IFG_BYTES = MIN_IFG_BEATS * BEAT_BYTES;
  localparam logic [31:0] CNT_RST = 32'h0000_0000;
  localparam logic [2:0] XT_IDLE = 3'h0;
  localparam logic [2:0] XT_START = 3'h1;
  localparam logic [2:0] XT_DATA = 3'h2;
  localparam logic [2:0] XT_TERM = 3'h3;
endpackage

// file: hdl/interval_acc.sv
// one accumulator with a held copy refreshed at each interval edge
// assumes add_in is in bytes and arrives on clk_in
`timescale 1ns/1ps
`default_nettype none
module interval_acc
  import tput_pkg::*;
#(
  parameter int W = CNT_W
) (
  input wire logic clk_in, // system clock
  input wire logic sys_rst_in, // async reset
  input wire logic tick_in, // interval boundary pulse
  input wire logic [7:0] add_in, // bytes this cycle
  output logic [W-1:0] total_out // last interval total
);
  logic [W-1:0] acc_r, acc_nxt, tot_r, tot_nxt;
  always_comb begin
    acc_nxt = acc_r + W'(add_in);
    tot_nxt = tot_r;
    if (tick_in) begin
      tot_nxt = acc_r + W'(add_in);
      acc_nxt = '0;
    end
  end
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      acc_r <= '0;
      tot_r <= '0;
    end else begin
      acc_r <= acc_nxt;
      tot_r <= tot_nxt;
    end
  end
  assign total_out = tot_r;
  snap_hold_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !tick_in |=> total_out == $past(total_out)) else $error("total changed off tick");
  snap_clear_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    tick_in |=> acc_r == '0) else $error("accumulator not restarted");
endmodule
`default_nettype wire

// file: hdl/throughput_monitor.sv
// throughput monitor: snoops PCIe transaction streams, DMA engines, link framer
// assumes all inputs are on clk_in; byte counts per beat are given by the snooped logic
// How it works
// - each DMA engine has its own completed payload byte counter.
// - every transmit transfer counted, headers included, in tx utilization.
// - every receive transfer counted, headers included, in rx utilization.
// - tx payload sums only upstream memory-write payload.
// - rx payload sums only downstream completion-with-data payload.
// - all totals refresh once per second; software reads at that period.
// - link transmitter keeps at least three idle beats between packets.
// - each packet has one start and one terminate character, two bytes.
// - link data path is 64 bits at 156.25 MHz.
`timescale 1ns/1ps
`default_nettype none
module throughput_monitor
  import tput_pkg::*;
#(
  parameter int N_ENG = 4,
  parameter int TICK_CYC = INTERVAL_CYC,
  parameter int W = CNT_W
) (
  input wire logic clk_in, // system clock
  input wire logic sys_rst_in, // async reset
  input wire logic [N_ENG-1:0] eng_done_vld_in, // engine delivered bytes
  input wire logic [N_ENG*8-1:0] eng_done_bytes_in, // bytes per engine
  input wire logic tx_vld_in, // tx beat valid
  input wire logic tx_rdy_in, // tx beat ready
  input wire logic [7:0] tx_bytes_in, // tx beat bytes incl header
  input wire logic tx_mwr_in, // tx beat is memory write
  input wire logic [7:0] tx_pay_in, // tx payload bytes in beat
  input wire logic rx_vld_in, // rx beat valid
  input wire logic rx_rdy_in, // rx beat ready
  input wire logic [7:0] rx_bytes_in, // rx beat bytes incl header
  input wire logic rx_cpld_in, // rx beat is completion with data
  input wire logic [7:0] rx_pay_in, // rx payload bytes in beat
  input wire logic [2:0] link_kind_in, // link beat kind
  output logic [N_ENG*W-1:0] eng_total_out, // per engine totals
  output logic [W-1:0] tx_util_out, // tx utilization total
  output logic [W-1:0] rx_util_out, // rx utilization total
  output logic [W-1:0] tx_pay_out, // tx payload total
  output logic [W-1:0] rx_pay_out, // rx payload total
  output logic [W-1:0] link_ovh_out, // link framing+minimum gap bytes total
  output logic tick_out, // interval boundary pulse
  output logic ifg_err_out, // gap shorter than minimum seen
  output logic frame_err_out // start/terminate out of order seen
);
  localparam int TW = $clog2(TICK_CYC + 1);
  logic [TW-1:0] tcnt_r, tcnt_nxt;
  logic tick_r, tick_nxt;
  logic tx_go, rx_go;
  logic [7:0] tx_add, rx_add, txp_add, rxp_add, ovh_add;

  always_comb begin
    tcnt_nxt = tcnt_r + TW'(1);
    tick_nxt = 1'b0;
    if (tcnt_r == TW'(TICK_CYC - 1)) begin
      tcnt_nxt = '0;
      tick_nxt = 1'b1;
    end
  end
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      tcnt_r <= '0;
      tick_r <= 1'b0;
    end else begin
      tcnt_r <= tcnt_nxt;
      tick_r <= tick_nxt;
    end
  end
  assign tick_out = tick_r;

  assign tx_go = tx_vld_in & tx_rdy_in;
  assign rx_go = rx_vld_in & rx_rdy_in;
  assign tx_add = tx_go ? tx_bytes_in : 8'h00;
  assign rx_add = rx_go ? rx_bytes_in : 8'h00;
  assign txp_add = (tx_go && tx_mwr_in) ? tx_pay_in : 8'h00;
  assign rxp_add = (rx_go && rx_cpld_in) ? rx_pay_in : 8'h00;

  genvar g;
  generate
    for (g = 0; g < N_ENG; g++) begin : g_eng
      logic [7:0] eng_add;
      assign eng_add = eng_done_vld_in[g] ? eng_done_bytes_in[g*8 +: 8] : 8'h00;
      interval_acc #(.W(W)) u_eng (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .tick_in(tick_r),
        .add_in(eng_add),
        .total_out(eng_total_out[g*W +: W])
      );
      eng_idle_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        !eng_done_vld_in[g] |-> eng_add == 8'h00) else $error("idle engine counted");
    end
  endgenerate
  interval_acc #(.W(W)) u_txu (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .tick_in(tick_r), .add_in(tx_add), .total_out(tx_util_out));
  interval_acc #(.W(W)) u_rxu (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .tick_in(tick_r), .add_in(rx_add), .total_out(rx_util_out));
  interval_acc #(.W(W)) u_txp (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .tick_in(tick_r), .add_in(txp_add), .total_out(tx_pay_out));
  interval_acc #(.W(W)) u_rxp (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .tick_in(tick_r), .add_in(rxp_add), .total_out(rx_pay_out));
  interval_acc #(.W(W)) u_ovh (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .tick_in(tick_r), .add_in(ovh_add), .total_out(link_ovh_out));

  // link path width and rate figures
  localparam int LINK_MBPS = LINK_DATA_W * LINK_CLK_KHZ / 1000;

  // link framing checker; data beats of the 64-bit link arrive one per cycle
  typedef enum logic [1:0] {LK_GAP, LK_PKT} lk_state_t;
  lk_state_t lk_r, lk_nxt;
  logic [3:0] gap_r, gap_nxt;
  logic ifg_r, ifg_nxt, fr_r, fr_nxt;
  always_comb begin
    lk_nxt = lk_r;
    gap_nxt = gap_r;
    ifg_nxt = ifg_r;
    fr_nxt = fr_r;
    ovh_add = 8'h00;
    case (lk_r)
      LK_GAP: begin
        if (link_kind_in == XT_IDLE) begin
          if (gap_r != 4'hF) gap_nxt = gap_r + 4'h1;
        end else if (link_kind_in == XT_START) begin
          if (gap_r < 4'(MIN_IFG_BEATS)) ifg_nxt = 1'b1;
          // start and terminate bytes plus minimum gap
          ovh_add = 8'(FRAME_CHAR_BYTES + MIN_IFG_BYTES);
          lk_nxt = LK_PKT;
        end else begin
          fr_nxt = 1'b1;
        end
      end
      LK_PKT: begin
        if (link_kind_in == XT_TERM) begin
          gap_nxt = 4'h0;
          lk_nxt = LK_GAP;
        end else if (link_kind_in != XT_DATA) begin
          fr_nxt = 1'b1;
        end
      end
      default: lk_nxt = LK_GAP;
    endcase
  end
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      lk_r <= LK_GAP;
      gap_r <= 4'(MIN_IFG_BEATS);
      ifg_r <= 1'b0;
      fr_r <= 1'b0;
    end else begin
      lk_r <= lk_nxt;
      gap_r <= gap_nxt;
      ifg_r <= ifg_nxt;
      fr_r <= fr_nxt;
    end
  end
  assign ifg_err_out = ifg_r;
  assign frame_err_out = fr_r;

  tick_period_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    tick_r |=> !tick_r) else $error("tick lasted two cycles");
  tick_count_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    tick_r |-> tcnt_r == '0) else $error("tick off interval");
  tx_payload_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !tx_mwr_in |-> txp_add == 8'h00) else $error("non write payload counted");
  rx_payload_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !rx_cpld_in |-> rxp_add == 8'h00) else $error("non completion counted");
  tx_util_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    tx_go |-> tx_add == tx_bytes_in) else $error("tx beat missed");
  tx_idle_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !tx_go |-> tx_add == 8'h00) else $error("refused tx beat counted");
  rx_util_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    rx_go |-> rx_add == rx_bytes_in) else $error("rx beat missed");
  rx_idle_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !rx_go |-> rx_add == 8'h00) else $error("refused rx beat counted");
  short_gap_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (lk_r == LK_GAP && link_kind_in == XT_START && gap_r < 4'(MIN_IFG_BEATS))
    |=> ifg_err_out) else $error("short gap not flagged");
  ifg_sticky_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    ifg_err_out |=> ifg_err_out) else $error("gap flag dropped");
  frame_ovh_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (lk_r == LK_GAP && link_kind_in == XT_START) |-> ovh_add == 8'h1A)
    else $error("framing bytes wrong");
  ovh_quiet_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !(lk_r == LK_GAP && link_kind_in == XT_START) |-> ovh_add == 8'h00)
    else $error("overhead counted off start");
  pkt_start_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (lk_r == LK_PKT && link_kind_in == XT_START) |=> frame_err_out)
    else $error("start inside packet not flagged");
  frame_sticky_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    frame_err_out |=> frame_err_out) else $error("frame flag dropped");
  link_rate_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    LINK_MBPS == 32'h0000_2710) else $error("link rate wrong");

  // main scenarios
  tick_c: cover property (@(posedge clk_in) tick_r);
  pkt_c: cover property (@(posedge clk_in) lk_r == LK_PKT && link_kind_in == XT_TERM);
  gap_c: cover property (@(posedge clk_in) ifg_r);
  min_gap_c: cover property (@(posedge clk_in)
    lk_r == LK_GAP && link_kind_in == XT_START && gap_r == 4'(MIN_IFG_BEATS));
  frame_c: cover property (@(posedge clk_in) fr_r);
endmodule
`default_nettype wire

// file: test/far_side.sv
// far-side model: stream snoop sources, DMA engines and link framer beats
// assumes beat() is called from the bench; it drives just after a falling edge
`timescale 1ns/1ps
`default_nettype none
module far_side (
  input wire logic clk_in, // system clock
  output logic [3:0] ev_out, // engine done valid
  output logic [31:0] eb_out, // engine byte lanes
  output logic tv_out, // tx valid
  output logic tr_out, // tx ready
  output logic [7:0] tb_out, // tx beat bytes
  output logic tm_out, // tx memory write
  output logic [7:0] tp_out, // tx payload bytes
  output logic rv_out, // rx valid
  output logic rr_out, // rx ready
  output logic [7:0] rb_out, // rx beat bytes
  output logic rc_out, // rx completion with data
  output logic [7:0] rp_out, // rx payload bytes
  output logic [2:0] lk_out // link beat kind
);
  initial {ev_out, eb_out, tv_out, tr_out, tb_out, tm_out, tp_out} = '0;
  initial {rv_out, rr_out, rb_out, rc_out, rp_out, lk_out} = '0;
  task automatic beat(input logic tv, tr, input logic [7:0] tb, input logic tm,
                      input logic [7:0] tp, input logic rv, rr, input logic [7:0] rb,
                      input logic rc, input logic [7:0] rp, input logic [3:0] ev,
                      input logic [31:0] eb, input logic [2:0] lk);
    @(negedge clk_in);
    {tv_out, tr_out, tm_out, rv_out, rr_out, rc_out} = {tv, tr, tm, rv, rr, rc};
    // tx and rx lanes without valid show the inverse, never stale data; engine lanes pass as given
    tb_out = tv ? tb : ~tb;
    tp_out = tv ? tp : ~tp;
    rb_out = rv ? rb : ~rb;
    rp_out = rv ? rp : ~rp;
    {ev_out, eb_out, lk_out} = {ev, eb, lk};
  endtask
endmodule
`default_nettype wire

// file: test/tb_top.sv
// self-checking bench for the throughput monitor with a 20-cycle interval
// assumes far_side drives every monitor input except clk_in and sys_rst_in, which the bench drives
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import tput_pkg::*;
  localparam int TK = 20;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [3:0] ev;
  logic [31:0] eb, u_tx, u_rx, p_tx, p_rx, ovh;
  logic tv, tr, tm, rv, rr, rc, tick, ifg, fre;
  logic [7:0] tb, tp, rb, rp;
  logic [2:0] lk;
  logic [127:0] eng;
  int errors = 0;
  int check_count = 0;
  always #50 clk_in = ~clk_in;
  far_side far (.clk_in(clk_in), .ev_out(ev), .eb_out(eb), .tv_out(tv), .tr_out(tr),
    .tb_out(tb), .tm_out(tm), .tp_out(tp), .rv_out(rv), .rr_out(rr), .rb_out(rb),
    .rc_out(rc), .rp_out(rp), .lk_out(lk));
  throughput_monitor #(.N_ENG(4), .TICK_CYC(TK)) dut (.clk_in(clk_in),
    .sys_rst_in(sys_rst_in), .eng_done_vld_in(ev), .eng_done_bytes_in(eb),
    .tx_vld_in(tv), .tx_rdy_in(tr), .tx_bytes_in(tb), .tx_mwr_in(tm), .tx_pay_in(tp),
    .rx_vld_in(rv), .rx_rdy_in(rr), .rx_bytes_in(rb), .rx_cpld_in(rc), .rx_pay_in(rp),
    .link_kind_in(lk), .eng_total_out(eng), .tx_util_out(u_tx), .rx_util_out(u_rx),
    .tx_pay_out(p_tx), .rx_pay_out(p_rx), .link_ovh_out(ovh), .tick_out(tick),
    .ifg_err_out(ifg), .frame_err_out(fre));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %0h seen %0h", n, e, g);
    end
  endtask
  task automatic close_out();
    if (errors == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // returns at the falling edge inside the tick cycle
  task automatic wait_tick();
    for (int i = 0; i < 2 * TK; i++) begin
      @(negedge clk_in);
      if (tick === 1'b1) return;
    end
    errors++;
    close_out();
  endtask
  task automatic idle(input logic [2:0] k);
    far.beat(1'h0, 1'h0, 8'h00, 1'h0, 8'h00, 1'h0, 1'h0, 8'h00, 1'h0, 8'h00, 4'h0, 32'h0, k);
  endtask
  task automatic t_period();
    int n;
    wait_tick();
    n = 0;
    do begin
      @(negedge clk_in);
      n++;
    end while (tick !== 1'b1 && n < 2 * TK);
    chk("tick_period", TK, n);
  endtask
  task automatic t_count();
    wait_tick();
    far.beat(1'h1, 1'h1, 8'h08, 1'h1, 8'h08, 1'h1, 1'h1, 8'h08, 1'h1, 8'h04, 4'h1, 32'h0A,
             XT_START);
    far.beat(1'h1, 1'h0, 8'h08, 1'h1, 8'h08, 1'h0, 1'h1, 8'h08, 1'h1, 8'h08, 4'h8,
             32'h05000000, XT_DATA);
    far.beat(1'h1, 1'h1, 8'h06, 1'h0, 8'h06, 1'h1, 1'h1, 8'h03, 1'h0, 8'h03, 4'h0, 32'h0,
             XT_TERM);
    far.beat(1'h1, 1'h1, 8'h08, 1'h1, 8'h02, 1'h1, 1'h1, 8'h08, 1'h1, 8'h08, 4'h3,
             32'h00330307, XT_IDLE);
    idle(XT_IDLE);
    idle(XT_IDLE);
    idle(XT_START);
    idle(XT_TERM);
    idle(XT_IDLE);
    wait_tick();
    @(negedge clk_in);
    chk("eng0", 32'h11, eng[31:0]);
    chk("eng1", 32'h03, eng[63:32]);
    chk("eng2", 32'h00, eng[95:64]);
    chk("eng3", 32'h05, eng[127:96]);
    chk("tx_util", 32'h16, u_tx);
    chk("rx_util", 32'h13, u_rx);
    chk("tx_pay", 32'h0A, p_tx);
    chk("rx_pay", 32'h0C, p_rx);
    chk("link_ovh", 2 * (FRAME_CHAR_BYTES + MIN_IFG_BYTES), ovh);
    chk("gap_err", 32'h0, {31'h0, ifg});
    chk("frame_err", 32'h0, {31'h0, fre});
  endtask
  task automatic t_errors();
    idle(XT_START);
    idle(XT_TERM);
    idle(XT_IDLE);
    idle(XT_START);
    idle(XT_TERM);
    idle(XT_TERM);
    idle(XT_IDLE);
    wait_tick();
    @(negedge clk_in);
    chk("gap_err", 32'h1, {31'h0, ifg});
    chk("frame_err", 32'h1, {31'h0, fre});
    chk("link_ovh_err", 2 * (FRAME_CHAR_BYTES + MIN_IFG_BYTES), ovh);
    chk("tx_util_restart", 32'h0, u_tx);
  endtask
  // mid-run reset clears flags and totals; first start right after release is legal
  task automatic t_reset();
    @(negedge clk_in);
    sys_rst_in = 1'b1;
    repeat (2) @(negedge clk_in);
    idle(XT_START);
    sys_rst_in = 1'b0;
    idle(XT_TERM);
    idle(XT_IDLE);
    chk("totals_reset", 32'h0, u_tx | u_rx | p_tx | p_rx | ovh | eng[31:0]);
    chk("gap_err_reset", 32'h0, {31'h0, ifg});
    chk("frame_err_reset", 32'h0, {31'h0, fre});
  endtask
  initial begin
    repeat (20) @(negedge clk_in);
    sys_rst_in = 1'b0;
    @(negedge clk_in);
    chk("totals", 32'h0, u_tx | u_rx | p_tx | p_rx | ovh);
    t_period();
    t_count();
    t_errors();
    t_reset();
    close_out();
  end
endmodule
`default_nettype wire
